// ===== logic/cac_control.sv
/*
 * Counter array control/mode registers, 16-bit counter, timebase select
 * and module 4 watchdog. Assumes SFR strobes synchronous to clk_i, one
 * cycle wide, and synchronous external pins except ext_clk_i, which is
 * divided and resynchronised here.
 */
`timescale 1ns/100ps
`include "cac_map.svh"
module cac_control import cac_pkg::*; (
    input wire logic clk_i, // system clock, 50 MHz
    input wire logic rst_i, // async reset, active high
    input wire cac_sfr_req_type sfr_i, // sfr access request
    output logic [7:0] sfr_rdata_o, // read data, registered
    input wire logic cpu_idle_i, // cpu in idle mode
    input wire logic tmr0_ovf_i, // timer 0 overflow pulse
    input wire logic count_pin_i, // external count pin
    input wire logic ext_clk_i, // external clock input
    input wire logic [4:0] module_event_i, // per-module match/capture
    input wire logic [4:0] module_irq_en_i, // per-module flag irq enable
    output logic irq_o, // counter array interrupt request
    output logic wdt_reset_o, // watchdog reset pulse, registered
    output logic [15:0] count_o // counter value, registered
);
    logic [7:0] ctl_reg; // overflow, run, module flags
    cac_mode_type mode_reg;
    logic [15:0] cnt_reg;
    logic [7:0] m4_low_reg;
    logic [7:0] m4_high_reg;
    logic [3:0] div_reg;
    logic pin_d1_reg;
    logic pin_d2_reg;
    logic [2:0] ext_div_reg; // runs on ext_clk_i
    logic ext_s1_reg;
    logic ext_s2_reg;
    logic ext_s3_reg;
    logic wdt_reset_reg;
    logic [7:0] rdata_reg;
    logic tick;
    logic running;
    logic wrap;
    logic low_wrap;
    logic wdt_on;
    logic wr_ctl;
    logic wr_mode;

    function automatic logic wr_at(input cac_sfr_req_type r,
                                   input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction

    assign wr_ctl = wr_at(sfr_i, `CAC_ADDR_CONTROL);
    assign wr_mode = wr_at(sfr_i, `CAC_ADDR_MODE);
    assign wdt_on = mode_reg.watchdog_enable;

    // prescaler for /12 and /4; free running keeps the phase simple
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_reg <= 4'h0;
        end else if (div_reg == `CAC_DIV12_LAST) begin
            div_reg <= 4'h0;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end

    // count pin: sampled twice to find the falling edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_d1_reg <= 1'b1;
            pin_d2_reg <= 1'b1;
        end else begin
            pin_d1_reg <= count_pin_i;
            pin_d2_reg <= pin_d1_reg;
        end
    end

    // external clock divided by eight in its own domain
    always_ff @(posedge ext_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_div_reg <= 3'h0;
        end else begin
            ext_div_reg <= ext_div_reg + 3'h1;
        end
    end

    // msb of divider is a level; two-flop sync, then edge detect
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
        end else begin
            ext_s1_reg <= ext_div_reg[2];
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
        end
    end

    // timebase mux; reserved codes give no ticks
    always_comb begin
        case (mode_reg.timebase_select)
            CAC_TB_DIV12: tick = (div_reg == `CAC_DIV12_LAST);
            CAC_TB_DIV4: tick = (div_reg[1:0] == `CAC_DIV4_LAST);
            CAC_TB_TMR0: tick = tmr0_ovf_i;
            CAC_TB_PIN: tick = pin_d2_reg && !pin_d1_reg;
            CAC_TB_SYSCLK: tick = 1'b1;
            CAC_TB_EXT8: tick = ext_s2_reg && !ext_s3_reg;
            default: tick = 1'b0;
        endcase
    end

    // watchdog forces the counter on; idle suspend still applies
    assign running = (ctl_reg[`CAC_CTL_RUN_BIT] || wdt_on)
                     && !(mode_reg.idle_suspend && cpu_idle_i)
                     && tick;
    assign low_wrap = running && (cnt_reg[7:0] == 8'hFF);
    assign wrap = running && (cnt_reg == 16'hFFFF);

    // counter; bytes writable only with the watchdog off
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= 16'h0000;
        end else if (!wdt_on && wr_at(sfr_i, `CAC_ADDR_CNT_LOW)) begin
            cnt_reg[7:0] <= sfr_i.wdata;
        end else if (!wdt_on && wr_at(sfr_i, `CAC_ADDR_CNT_HIGH)) begin
            cnt_reg[15:8] <= sfr_i.wdata;
        end else if (running) begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end

    // control flags: hardware set wins over a software clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctl_reg <= `CAC_CTL_RESET;
        end else begin
            ctl_reg <= ((wr_ctl ? sfr_i.wdata : ctl_reg)
                        | {wrap, 2'b00, module_event_i})
                       & `CAC_CTL_MASK;
        end
    end

    // mode register; locked content while the watchdog runs
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_reg <= cac_mode_type'(`CAC_MODE_RESET);
        end else if (wr_mode) begin
            if (!wdt_on) begin
                mode_reg <= cac_mode_type'(sfr_i.wdata & `CAC_MODE_MASK);
                mode_reg.watchdog_enable <= sfr_i.wdata[`CAC_MODE_WDE_BIT]
                    || sfr_i.wdata[`CAC_MODE_LOCK_BIT];
            end else if (!mode_reg.watchdog_lock) begin
                // only the enable/lock pair may change here
                mode_reg.watchdog_enable <= sfr_i.wdata[`CAC_MODE_WDE_BIT]
                    || sfr_i.wdata[`CAC_MODE_LOCK_BIT];
                mode_reg.watchdog_lock <= sfr_i.wdata[`CAC_MODE_LOCK_BIT];
            end
        end
    end

    // module 4 compare bytes; high write reloads from counter plus offset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            m4_low_reg <= 8'h00;
            m4_high_reg <= 8'h00;
        end else if (wr_at(sfr_i, `CAC_ADDR_M4_LOW)) begin
            m4_low_reg <= sfr_i.wdata;
        end else if (wr_at(sfr_i, `CAC_ADDR_M4_HIGH)) begin
            m4_high_reg <= cnt_reg[15:8] + m4_low_reg;
        end
    end

    // watchdog reset: timeout or forced by writing module 4 flag
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wdt_reset_reg <= 1'b0;
        end else begin
            wdt_reset_reg <= wdt_on && ((low_wrap
                && m4_high_reg == cnt_reg[15:8])
                || (wr_ctl && sfr_i.wdata[`CAC_CTL_M4_BIT]));
        end
    end

    // read mux; run bit reads what software wrote, not the forced run
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg <= 8'h00;
        end else if (sfr_i.addr == `CAC_ADDR_CONTROL) begin
            rdata_reg <= ctl_reg;
        end else if (sfr_i.addr == `CAC_ADDR_MODE) begin
            rdata_reg <= mode_reg & `CAC_MODE_MASK;
        end else if (sfr_i.addr == `CAC_ADDR_CNT_LOW) begin
            rdata_reg <= cnt_reg[7:0];
        end else if (sfr_i.addr == `CAC_ADDR_CNT_HIGH) begin
            rdata_reg <= cnt_reg[15:8];
        end else if (sfr_i.addr == `CAC_ADDR_M4_LOW) begin
            rdata_reg <= m4_low_reg;
        end else if (sfr_i.addr == `CAC_ADDR_M4_HIGH) begin
            rdata_reg <= m4_high_reg;
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    // one shared request line for overflow and module flags
    assign irq_o = (ctl_reg[`CAC_CTL_OVF_BIT]
                    && mode_reg.overflow_irq_enable)
                   || |(ctl_reg[4:0] & module_irq_en_i);
    assign sfr_rdata_o = rdata_reg;
    assign wdt_reset_o = wdt_reset_reg;
    assign count_o = cnt_reg;

    a_wrap_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        wrap |=> ctl_reg[`CAC_CTL_OVF_BIT])
        else $error("overflow flag not set after wrap");
    a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        ($fell(ctl_reg[0]) || $fell(ctl_reg[7])) |-> $past(wr_ctl))
        else $error("flag cleared without software write");
    a_irq_masked: assert property (@(posedge clk_i) disable iff (rst_i)
        (module_irq_en_i == 5'h00 && !mode_reg.overflow_irq_enable)
        |-> !irq_o)
        else $error("interrupt raised while masked");
    a_stop_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        (!ctl_reg[6] && !wdt_on && !sfr_i.wr) |=> $stable(cnt_reg))
        else $error("counter moved while stopped");
    a_unused_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctl_reg[5] && !mode_reg[4])
        else $error("unused bit read one");
    a_lock_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg.watchdog_lock |=> mode_reg.watchdog_enable)
        else $error("watchdog disabled while locked");
    a_mode_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
        wdt_on |=> $stable(mode_reg.timebase_select)
                   && $stable(mode_reg.idle_suspend))
        else $error("mode changed with watchdog on");
    a_idle_stops: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_reg.idle_suspend && cpu_idle_i && !sfr_i.wr)
        |=> $stable(cnt_reg))
        else $error("counter moved in suspended idle");
    a_force_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        (wdt_on && wr_ctl && sfr_i.wdata[4]) |=> wdt_reset_o)
        else $error("forced watchdog reset missing");
    a_sysclk_step: assert property (@(posedge clk_i) disable iff (rst_i)
        running |=> cnt_reg == $past(cnt_reg) + 16'h0001)
        else $error("counter did not step by one");
endmodule

// ===== common/cac_map.svh
/*
 * Register offsets, field positions and reset values of the counter array
 * control and mode registers. Assumes an 8-bit special function register
 * port with byte addresses and single-cycle read and write strobes.
 */
// Contract
// - Wrap from 0xFFFF to zero sets overflow flag
// - Event flags stay set until software clears
// - Overflow flag raises interrupt when enabled
// - Run control: 0 stops, 1 counts
// - Modules 0-4 flags in bits 0-4
// - Enabled module flag raises shared interrupt
// - Unused control bit5, mode bit4 read zero
// - Watchdog enable makes module 4 watchdog
// - Lock set forbids disabling until reset
// - Idle suspend stops counter during CPU idle
// - Timebase select picks one of six sources
// - External clock divided by eight, synchronised
// - Watchdog enabled blocks other mode bit writes
// - Watchdog forces run, freezes counter writes
// - Low byte overflow with high match resets
// - Compare high write loads high plus offset
// - Writing module 4 flag forces watchdog reset
`ifndef CAC_MAP_SVH
`define CAC_MAP_SVH
`define CAC_ADDR_CONTROL 8'hD8
`define CAC_ADDR_MODE 8'hD9
`define CAC_ADDR_CNT_LOW 8'hE9
`define CAC_ADDR_CNT_HIGH 8'hF9
`define CAC_ADDR_M4_LOW 8'hEE
`define CAC_ADDR_M4_HIGH 8'hFE
`define CAC_CTL_OVF_BIT 7
`define CAC_CTL_RUN_BIT 6
`define CAC_CTL_M4_BIT 4
`define CAC_MODE_IDLE_BIT 7
`define CAC_MODE_WDE_BIT 6
`define CAC_MODE_LOCK_BIT 5
`define CAC_MODE_TB_LSB 1
`define CAC_MODE_IRQ_BIT 0
`define CAC_CTL_RESET 8'h00
`define CAC_MODE_RESET 8'h40
`define CAC_CTL_MASK 8'hDF
`define CAC_MODE_MASK 8'hEF
`define CAC_DIV12_LAST 4'h0B
`define CAC_DIV4_LAST 2'h3
`endif

// ===== common/cac_pkg.sv
/*
 * Types shared by the counter array control block.
 * Assumes the map header supplies all numbers.
 */
package cac_pkg;
    typedef enum logic [2:0] {
        CAC_TB_DIV12,
        CAC_TB_DIV4,
        CAC_TB_TMR0,
        CAC_TB_PIN,
        CAC_TB_SYSCLK,
        CAC_TB_EXT8,
        CAC_TB_RSV6,
        CAC_TB_RSV7
    } cac_timebase_type;

    typedef struct packed {
        logic idle_suspend;
        logic watchdog_enable;
        logic watchdog_lock;
        logic unused_zero; // bit 4, always zero; keeps the byte layout
        cac_timebase_type timebase_select;
        logic overflow_irq_enable;
    } cac_mode_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cac_sfr_req_type;
endpackage

// ===== testbench/tb.sv
/*
 * Self-checking bench for the counter array control block.
 * Assumes one 50 MHz clock and sfr strobes driven on its rising edge.
 */
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
    import cac_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    cac_sfr_req_type sfr_i = '0;
    logic [7:0] sfr_rdata_o;
    logic cpu_idle_i = 1'b0;
    logic tmr0_ovf_i = 1'b0;
    logic count_pin_i = 1'b1;
    logic ext_clk_i = 1'b0;
    logic [4:0] module_event_i = '0;
    logic [4:0] module_irq_en_i = '0;
    logic irq_o;
    logic wdt_reset_o;
    logic [15:0] count_o;
    logic [15:0] c0;
    logic [7:0] rd_v;
    logic seen;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;
    // mode bytes per timebase case; the last two exercise idle suspend
    logic [7:0] modes [9] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A,
        8'h0C, 8'h88, 8'h08};
    int exp_ticks [9] = '{16, 48, 5, 20, 192, 4, 0, 0, 192};

    cac_control i_cac_control (.clk_i(clk_i), .rst_i(rst_i), .sfr_i(sfr_i),
        .sfr_rdata_o(sfr_rdata_o), .cpu_idle_i(cpu_idle_i),
        .tmr0_ovf_i(tmr0_ovf_i), .count_pin_i(count_pin_i),
        .ext_clk_i(ext_clk_i), .module_event_i(module_event_i),
        .module_irq_en_i(module_irq_en_i), .irq_o(irq_o),
        .wdt_reset_o(wdt_reset_o), .count_o(count_o));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    // hang guard: the whole sequence needs about 2500 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 12000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (n_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one-cycle write strobe; returns just after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        sfr_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        sfr_i.wr <= 1'b0;
        #1;
    endtask

    // read data is registered one cycle after the address
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        sfr_i.addr <= a;
        @(posedge clk_i);
        #1 rd_v = sfr_rdata_o;
    endtask

    task automatic t_regs();
        rd(8'hD8);
        `CHK(rd_v, 8'h00)
        rd(8'hD9);
        `CHK(rd_v, 8'h40)
        rd(8'h00);
        `CHK(rd_v, 8'h00)
        wr(8'hD9, 8'h10);
        rd(8'hD9);
        `CHK(rd_v, 8'h00)
        wr(8'hD8, 8'h3F);
        rd(8'hD8);
        `CHK(rd_v, 8'h1F)
        wr(8'hD8, 8'h00);
    endtask

    task automatic t_events();
        @(posedge clk_i);
        module_event_i <= 5'h0A;
        @(posedge clk_i);
        module_event_i <= 5'h00;
        repeat (20) @(posedge clk_i);
        rd(8'hD8);
        `CHK(rd_v, 8'h0A)
        `CHK(irq_o, 1'b0)
        @(posedge clk_i);
        module_irq_en_i <= 5'h02;
        #1;
        `CHK(irq_o, 1'b1)
        @(posedge clk_i);
        module_irq_en_i <= 5'h04;
        #1;
        `CHK(irq_o, 1'b0)
        wr(8'hD8, 8'h00);
        rd(8'hD8);
        `CHK(rd_v, 8'h00)
    endtask

    task automatic t_overflow();
        wr(8'hD9, 8'h08);
        wr(8'hE9, 8'hF0);
        wr(8'hF9, 8'hFF);
        `CHK(count_o, 16'hFFF0)
        wr(8'hD8, 8'h40);
        repeat (30) @(posedge clk_i);
        // flag must come from the wrap, before software writes it
        rd(8'hD8);
        `CHK(rd_v, 8'hC0)
        wr(8'hD8, 8'h80);
        rd(8'hD8);
        `CHK(rd_v, 8'h80)
        `CHK(irq_o, 1'b0)
        wr(8'hD9, 8'h09);
        `CHK(irq_o, 1'b1)
        c0 = count_o;
        repeat (10) @(posedge clk_i);
        `CHK(count_o, c0)
        wr(8'hD9, 8'h08);
        wr(8'hD8, 8'h00);
    endtask

    // a fixed 192-cycle window, same phase at both samples
    task automatic t_timebase();
        logic [2:0] code;
        for (int k = 0; k < 9; k++) begin
            code = modes[k][3:1];
            wr(8'hD9, modes[k]);
            @(posedge clk_i);
            cpu_idle_i <= (k >= 7);
            wr(8'hD8, 8'h40);
            for (int i = 0; i <= 192; i++) begin
                @(posedge clk_i);
                tmr0_ovf_i <= (code == 3'd2 && i % 32 == 0 && i < 160);
                // falling edges at sysclk/8, inside the allowed rate
                count_pin_i <= !(code == 3'd3 && i < 160 && i % 8 < 4);
                ext_clk_i <= (code == 3'd5 && i < 128 && i % 4 >= 2);
                #1;
                if (i == 0) begin
                    c0 = count_o;
                end
            end
            `CHK(count_o - c0, 16'(exp_ticks[k]))
            @(posedge clk_i);
            cpu_idle_i <= 1'b0;
            wr(8'hD8, 8'h00);
        end
    endtask

    task automatic t_watchdog();
        wr(8'hEE, 8'h01);
        wr(8'hE9, 8'h00);
        wr(8'hF9, 8'h00);
        wr(8'hD9, 8'h48);
        rd(8'hD9);
        `CHK(rd_v, 8'h48)
        wr(8'hD9, 8'hCE);
        rd(8'hD9);
        `CHK(rd_v, 8'h48)
        c0 = count_o;
        repeat (10) @(posedge clk_i);
        #1;
        `CHK(count_o - c0, 16'h000A)
        wr(8'hFE, 8'h77);
        rd(8'hFE);
        `CHK(rd_v, 8'h01)
        n = 0;
        while (n < 700 && wdt_reset_o !== 1'b1) begin
            @(posedge clk_i);
            #1 n++;
        end
        `CHK(n > 256 && n < 520, 1'b1)
        wr(8'hD8, 8'h10);
        seen = wdt_reset_o;
        repeat (4) @(posedge clk_i) #1 seen |= wdt_reset_o;
        `CHK(seen, 1'b1)
        wr(8'hD9, 8'h68);
        wr(8'hD9, 8'h00);
        rd(8'hD9);
        `CHK(rd_v[6], 1'b1)
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'hD9);
        `CHK(rd_v, 8'h40)
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_events();
        t_overflow();
        t_timebase();
        t_watchdog();
        print_verdict();
    end
endmodule
